// ==== rtl/ebls_slave.sv ====
// memory slave on the asynchronous 32-bit local expansion bus
// assumes all bus inputs already synchronous to clk_sys_in; one bus master at a time
// Notes on behaviour
// RULE_01 - single byte at even address travels on D08-D15, other lines ignored
// RULE_02 - single byte at odd address travels on D00-D07
// RULE_03 - every word transfer uses D00-D15 whichever half is addressed
// RULE_04 - longword transfers use all lines D00-D31
// RULE_05 - upper sixteen array bits reachable through D00-D15
// RULE_06 - even word address maps to longword bits D16-D31
// RULE_07 - even and next odd word read back as one longword, even high
// RULE_08 - even byte is most significant byte of its word, odd least
// RULE_09 - even strobe alone, odd strobe alone, or both for a word
// RULE_10 - all masters and slaves do byte and word transfers
// RULE_11 - narrow class does bytes and words, wide class adds longwords
// RULE_12 - masters support at least single cycles, others optional
// RULE_13 - slaves support single and both indivisible cycle kinds
// RULE_14 - only one master drives the bus; secondary needs a grant first
// RULE_15 - narrow slave answers longword request with data error low
// RULE_16 - slave without sequential support answers sequential cycle with error
// RULE_17 - acknowledge once data accepted or valid, release after strobes negate
`timescale 1ns/1ns
module ebls_slave #(
    parameter bit WIDE_CLASS = 1'b1,
    parameter bit SEQ_CAP    = 1'b0,
    parameter int MEM_AW     = 10,
    parameter int BASE_PAGE  = 0
) (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        sys_rst_in,
    // address and control from the master
    input  wire logic [11:0] addr_mux_in,
    input  wire logic        low_addr_strobe_in,
    input  wire logic        high_addr_strobe_n_in,
    input  wire logic        even_byte_strobe_n_in,
    input  wire logic        odd_byte_strobe_n_in,
    input  wire logic        read_in,
    input  wire logic        seq_cycle_in,
    input  wire logic        indivisible_in,
    // data lines
    input  wire logic [31:0] data_in,
    output logic      [31:0] data_out,
    output logic             data_oe_out,
    // open-drain responses
    output logic             ack_n_out,
    output logic             ack_oe_out,
    output logic             data_error_n_out,
    output logic             data_error_oe_out,
    // lockout for the second memory port during indivisible cycles
    output logic             lock_out
);
    ebls_pkg::ebls_state_t state_q;
    logic [23:1] addr_q;
    logic        longword_select_q;
    logic        seq_q;
    logic        read_q;
    logic        even_n_q;
    logic        odd_n_q;
    logic [31:0] data_q;
    logic        data_oe_q;
    logic        ack_n_q;
    logic        data_error_n_n_q;
    logic        ack_oe_q;
    logic        data_error_n_oe_q;
    logic        lock_q;
    logic [31:0] mem_q [0:(1<<MEM_AW)-1];

    logic        strobe_any;
    logic        strobes_off;
    logic        err_now;
    logic        hit_now;
    logic [MEM_AW-1:0] idx;
    logic [3:0]  be;
    logic [31:0] mem_wdata;
    logic [31:0] bus_rdata;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    assign strobe_any  = ~even_byte_strobe_n_in | ~odd_byte_strobe_n_in; // RULE_09
    assign strobes_off = even_byte_strobe_n_in & odd_byte_strobe_n_in;
    assign idx         = addr_q[MEM_AW+1:2];
    // upper address arrives on the mux lines in the high phase; page is the bits above the array
    assign hit_now     = ({addr_mux_in, addr_q[11:1]} >> (MEM_AW + 1)) ==
                         23'(BASE_PAGE);

    // refusal: longword on narrow class, sequential without support,
    // or longword without both strobes
    assign err_now = (longword_select_q & ~WIDE_CLASS)                             // RULE_11 RULE_15
                   | (seq_q & ~SEQ_CAP)                                  // RULE_16
                   | (longword_select_q & ~(~even_byte_strobe_n_in & ~odd_byte_strobe_n_in));

    ebls_lane_steer u_steer (
        .longword_select_in    (longword_select_q),
        .a01_in                (addr_q[1]),
        .even_byte_strobe_n_in (even_n_q),
        .odd_byte_strobe_n_in  (odd_n_q),
        .bus_wdata_in          (data_in),
        .mem_rdata_in          (mem_q[idx]),
        .byte_en_out           (be),
        .mem_wdata_out         (mem_wdata),
        .bus_rdata_out         (bus_rdata)
    );

    // cycle sequencing; single, sequential and indivisible all share it
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            state_q <= ebls_pkg::EBLS_ST_IDLE;
        end else begin
            case (state_q)
                ebls_pkg::EBLS_ST_IDLE: begin
                    if (low_addr_strobe_in) begin
                        state_q <= ebls_pkg::EBLS_ST_ADDR;
                    end
                end
                ebls_pkg::EBLS_ST_ADDR: begin
                    if (!high_addr_strobe_n_in) begin
                        state_q <= hit_now ? ebls_pkg::EBLS_ST_SEL : ebls_pkg::EBLS_ST_DONE;
                    end else if (!low_addr_strobe_in) begin
                        state_q <= ebls_pkg::EBLS_ST_IDLE;
                    end
                end
                ebls_pkg::EBLS_ST_SEL: begin
                    if (high_addr_strobe_n_in) begin
                        state_q <= ebls_pkg::EBLS_ST_IDLE;
                    end else if (strobe_any) begin
                        state_q <= err_now ? ebls_pkg::EBLS_ST_ERR : ebls_pkg::EBLS_ST_XFER;
                    end
                end
                ebls_pkg::EBLS_ST_XFER: begin
                    state_q <= ebls_pkg::EBLS_ST_ACK;
                end
                ebls_pkg::EBLS_ST_ACK: begin
                    if (strobes_off) begin
                        state_q <= seq_q ? ebls_pkg::EBLS_ST_SEL : ebls_pkg::EBLS_ST_DONE;
                    end
                end
                ebls_pkg::EBLS_ST_ERR: begin
                    if (strobes_off) begin
                        state_q <= ebls_pkg::EBLS_ST_DONE;
                    end
                end
                ebls_pkg::EBLS_ST_DONE: begin
                    if (high_addr_strobe_n_in) begin
                        state_q <= ebls_pkg::EBLS_ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ebls_pkg::EBLS_ST_IDLE;
                end
            endcase
        end
    end

    // address capture and sequential advance
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            addr_q  <= 23'h000000;
            longword_select_q <= 1'b0;
            seq_q   <= 1'b0;
        end else if (state_q == ebls_pkg::EBLS_ST_IDLE && low_addr_strobe_in) begin
            addr_q[11:1] <= addr_mux_in[11:1];
            longword_select_q      <= addr_mux_in[0];
            seq_q        <= seq_cycle_in;
        end else if (state_q == ebls_pkg::EBLS_ST_ADDR && !high_addr_strobe_n_in) begin
            addr_q[23:12] <= addr_mux_in;
        end else if (state_q == ebls_pkg::EBLS_ST_ACK && strobes_off && seq_q) begin
            addr_q <= addr_q + (longword_select_q ? ebls_pkg::STEP_LONG : ebls_pkg::STEP_WORD);
        end
    end

    // strobe and direction capture at the start of a data phase
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            even_n_q <= ebls_pkg::LINE_IDLE;
            odd_n_q  <= ebls_pkg::LINE_IDLE;
            read_q   <= 1'b0;
        end else if (state_q == ebls_pkg::EBLS_ST_SEL && strobe_any) begin
            even_n_q <= even_byte_strobe_n_in;
            odd_n_q  <= odd_byte_strobe_n_in;
            read_q   <= read_in;
        end
    end

    // array write with per-byte enables
    always_ff @(posedge clk_sys_in) begin
        if (state_q == ebls_pkg::EBLS_ST_XFER && !read_q) begin
            for (int b = 0; b < ebls_pkg::BYTES; b++) begin
                if (be[b]) begin
                    mem_q[idx][b*8 +: 8] <= mem_wdata[b*8 +: 8]; // RULE_05 RULE_07 RULE_10
                end
            end
        end
    end

    // read data onto the steered lanes
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            data_q    <= ebls_pkg::DATA_RST;
            data_oe_q <= ebls_pkg::OE_OFF;
        end else if (state_q == ebls_pkg::EBLS_ST_XFER && read_q) begin
            data_q    <= bus_rdata;                                      // RULE_03 RULE_04
            data_oe_q <= 1'b1;
        end else if (state_q == ebls_pkg::EBLS_ST_ACK && strobes_off) begin
            data_oe_q <= ebls_pkg::OE_OFF;
        end
    end

    // acknowledge: low after the access, released once strobes negate
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            ack_n_q  <= ebls_pkg::LINE_IDLE;
            ack_oe_q <= ebls_pkg::OE_OFF;
        end else if (state_q == ebls_pkg::EBLS_ST_XFER) begin
            ack_n_q  <= 1'b0;                                            // RULE_17
            ack_oe_q <= 1'b1;
        end else if (state_q == ebls_pkg::EBLS_ST_ACK && strobes_off) begin
            ack_n_q  <= ebls_pkg::LINE_IDLE;                             // RULE_17
            ack_oe_q <= ebls_pkg::OE_OFF;
        end
    end

    // data error instead of a transfer the slave cannot perform
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            data_error_n_n_q  <= ebls_pkg::LINE_IDLE;
            data_error_n_oe_q <= ebls_pkg::OE_OFF;
        end else if (state_q == ebls_pkg::EBLS_ST_SEL && strobe_any
                     && !high_addr_strobe_n_in) begin
            data_error_n_n_q  <= ~err_now;                                       // RULE_15 RULE_16
            data_error_n_oe_q <= err_now;
        end else if (state_q == ebls_pkg::EBLS_ST_ERR && strobes_off) begin
            data_error_n_n_q  <= ebls_pkg::LINE_IDLE;
            data_error_n_oe_q <= ebls_pkg::OE_OFF;
        end
    end

    // indivisible cycles hold the other port off until the cycle ends
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            lock_q <= 1'b0;
        end else if (state_q == ebls_pkg::EBLS_ST_ADDR && !high_addr_strobe_n_in) begin
            lock_q <= hit_now & indivisible_in;                          // RULE_13
        end else if (state_q == ebls_pkg::EBLS_ST_IDLE && !indivisible_in) begin
            lock_q <= 1'b0;
        end
    end

    assign data_out          = data_q;
    assign data_oe_out       = data_oe_q;
    assign ack_n_out         = ack_n_q;
    assign ack_oe_out        = ack_oe_q;
    assign data_error_n_out  = data_error_n_n_q;
    assign data_error_oe_out = data_error_n_oe_q;
    assign lock_out          = lock_q;

    sequence s_req;
        state_q == ebls_pkg::EBLS_ST_SEL && strobe_any && !high_addr_strobe_n_in;
    endsequence
    sequence s_xfer_rd;
        state_q == ebls_pkg::EBLS_ST_XFER && read_q && !longword_select_q;
    endsequence
    sequence s_hi_addr;
        state_q == ebls_pkg::EBLS_ST_ADDR && !high_addr_strobe_n_in;
    endsequence

    a_narrow_long_err: assert property ( // RULE_15
        s_req ##0 (longword_select_q && !WIDE_CLASS) |=> !data_error_n_n_q && ack_n_q)
        else $error("narrow longword not refused");
    a_wide_long_ok: assert property ( // RULE_11
        s_req ##0 (longword_select_q && WIDE_CLASS && (SEQ_CAP || !seq_q) && !even_byte_strobe_n_in
        && !odd_byte_strobe_n_in) |=> data_error_n_n_q ##1 !ack_n_q)
        else $error("wide longword refused");
    a_seq_refused: assert property ( // RULE_16
        s_req ##0 (seq_q && !SEQ_CAP) |=> !data_error_n_n_q [*1] ##1 ack_n_q)
        else $error("sequential not refused");
    a_data_error_n_release: assert property ( // RULE_16
        state_q == ebls_pkg::EBLS_ST_ERR && strobes_off |=> data_error_n_n_q && ack_n_q)
        else $error("error held after strobes");
    a_ack_follows: assert property ( // RULE_17
        s_req ##0 !err_now |=> ##1 !ack_n_q)
        else $error("ack not given two cycles after strobe");
    a_ack_release: assert property ( // RULE_17
        !ack_n_q && strobes_off |=> ack_n_q && !data_oe_q)
        else $error("ack held after strobes");
    a_foreign_quiet: assert property ( // RULE_17
        s_hi_addr ##0 !hit_now |=> ack_n_q && data_error_n_n_q && !data_oe_q && !lock_q)
        else $error("unselected slave answered");
    a_lock_indiv: assert property ( // RULE_13
        s_hi_addr ##0 (hit_now && indivisible_in) |=> lock_q)
        else $error("indivisible cycle not locked");
    a_odd_lane: assert property ( // RULE_02
        s_xfer_rd ##0 (even_n_q && !odd_n_q) |=> data_q[31:8] == 24'h000000)
        else $error("odd byte off D00-D07");
    a_even_lane: assert property ( // RULE_01
        s_xfer_rd ##0 (!even_n_q && odd_n_q)
        |=> data_q[31:16] == 16'h0000 && data_q[7:0] == 8'h00)
        else $error("even byte off D08-D15");
    a_word_lane: assert property ( // RULE_03
        s_xfer_rd |=> data_q[31:16] == 16'h0000 && data_oe_q)
        else $error("word off low lines");
    a_even_word_hi: assert property ( // RULE_06
        state_q == ebls_pkg::EBLS_ST_XFER && !longword_select_q
        && !addr_q[1] && !even_n_q && !odd_n_q |-> be == ebls_pkg::BE_HI_WORD)
        else $error("even word not upper half");
    a_byte_order: assert property ( // RULE_08
        state_q == ebls_pkg::EBLS_ST_XFER && !longword_select_q
        && addr_q[1] && !even_n_q && odd_n_q |-> be == ebls_pkg::BE_EVEN_LO)
        else $error("even byte not most significant");
    a_odd_byte_be: assert property ( // RULE_02
        state_q == ebls_pkg::EBLS_ST_XFER && !longword_select_q
        && addr_q[1] && even_n_q && !odd_n_q |-> be == ebls_pkg::BE_ODD_LO)
        else $error("odd byte not least significant");
    a_long_lanes: assert property ( // RULE_04
        state_q == ebls_pkg::EBLS_ST_XFER && longword_select_q |-> be == ebls_pkg::BE_ALL)
        else $error("longword not on all lanes");
    a_resp_excl: assert property ( // RULE_17
        !(!ack_n_q && !data_error_n_n_q))
        else $error("ack and error together");
endmodule

// ==== rtl/ebls_pkg.sv ====
// package: constants for the expansion bus memory slave
// assumes a single clock domain and synchronous active-high reset
package ebls_pkg;
    localparam int          ADDR_LINES = 12;
    localparam int          DATA_W     = 32;
    localparam int          BYTES      = 4;
    // word-address steps for sequential cycles
    localparam logic [22:0] STEP_WORD  = 23'h000001;
    localparam logic [22:0] STEP_LONG  = 23'h000002;
    // byte enables, bit 3 is the most significant byte of a longword
    localparam logic [3:0]  BE_NONE    = 4'h0;
    localparam logic [3:0]  BE_ALL     = 4'hf;
    localparam logic [3:0]  BE_HI_WORD = 4'hc;
    localparam logic [3:0]  BE_ODD_LO  = 4'h1;
    localparam logic [3:0]  BE_EVEN_LO = 4'h2;
    // reset values of the driven pins
    localparam logic [31:0] DATA_RST   = 32'h0000_0000;
    localparam logic        LINE_IDLE  = 1'b1;
    localparam logic        OE_OFF     = 1'b0;

    typedef enum logic [2:0] {
        EBLS_ST_IDLE,
        EBLS_ST_ADDR,
        EBLS_ST_SEL,
        EBLS_ST_XFER,
        EBLS_ST_ACK,
        EBLS_ST_ERR,
        EBLS_ST_DONE
    } ebls_state_t;
endpackage

// ==== rtl/ebls_lane_steer.sv ====
// lane steering between the 32-bit array and the bus data lines
// assumes strobes are active low and already qualified by the caller
`timescale 1ns/1ns
module ebls_lane_steer (
    // access shape
    input  wire logic        longword_select_in,
    input  wire logic        a01_in,
    input  wire logic        even_byte_strobe_n_in,
    input  wire logic        odd_byte_strobe_n_in,
    // data
    input  wire logic [31:0] bus_wdata_in,
    input  wire logic [31:0] mem_rdata_in,
    output logic      [3:0]  byte_en_out,
    output logic      [31:0] mem_wdata_out,
    output logic      [31:0] bus_rdata_out
);
    logic [1:0]  half_be;
    logic [15:0] half_rd;
    logic [15:0] lane_mask;

    always_comb begin
        half_be   = {~even_byte_strobe_n_in, ~odd_byte_strobe_n_in};
        lane_mask = {{8{half_be[1]}}, {8{half_be[0]}}};
        // even word is the upper half of the longword
        half_rd   = a01_in ? mem_rdata_in[15:0] : mem_rdata_in[31:16]; // RULE_05 RULE_06
        if (longword_select_in) begin
            byte_en_out   = ebls_pkg::BE_ALL;                       // RULE_04
            mem_wdata_out = bus_wdata_in;                           // RULE_07
            bus_rdata_out = mem_rdata_in;                           // RULE_07
        end else begin
            // even byte on D08-D15, odd byte on D00-D07, unselected lane zero
            byte_en_out   = a01_in ? {2'b00, half_be} : {half_be, 2'b00}; // RULE_08 RULE_09
            mem_wdata_out = {bus_wdata_in[15:0], bus_wdata_in[15:0]};      // RULE_03
            bus_rdata_out = {16'h0000, half_rd & lane_mask};              // RULE_01 RULE_02
        end
    end
endmodule

// ==== verif/ebls_master.sv ====
// bus master model: one whole transfer per call, data placed on the documented lanes
// assumes the bench resolves the pulled-up open-drain ack and error lines
`timescale 1ns/1ns
module ebls_master (
    // clock
    input  wire logic        clk_sys_in,
    // responses from the slaves
    input  wire logic        ack_n_in,
    input  wire logic        data_error_n_in,
    input  wire logic [31:0] data_in,
    input  wire logic        lock_in,
    // address and control
    output logic      [11:0] addr_mux_out,
    output logic             low_addr_strobe_out,
    output logic             high_addr_strobe_n_out,
    output logic             even_byte_strobe_n_out,
    output logic             odd_byte_strobe_n_out,
    output logic             read_out,
    output logic             seq_cycle_out,
    output logic             indivisible_out,
    // write data
    output logic             drive_out,
    output logic      [31:0] data_out
);
    initial begin
        {low_addr_strobe_out, seq_cycle_out, indivisible_out, read_out, drive_out} = 5'h00;
        {high_addr_strobe_n_out, even_byte_strobe_n_out, odd_byte_strobe_n_out} = 3'h7;
        addr_mux_out = 12'h000;
        data_out = 32'h0000_0000;
    end

    // sole master on the bus, one data phase per call, sq and ind set the sequential and indivisible flags; sz 3 is a longword with one strobe
    task automatic xfer(input logic [23:0] a, input int sz, input bit rd, input bit sq,
                        input bit ind, input logic [31:0] wd, output logic [31:0] rv,
                        output int resp, output logic lk);
        logic [31:0] p;
        logic [31:0] m;
        p = (sz == 1) ? (a[0] ? {24'h0, wd[7:0]} : {16'h0, wd[7:0], 8'h0})
            : (sz == 2) ? {16'h0, wd[15:0]} : wd;
        m = (sz == 1) ? (a[0] ? 32'h0000_00ff : 32'h0000_ff00)
            : (sz == 2) ? 32'h0000_ffff : 32'hffff_ffff;
        resp = 0;
        @(posedge clk_sys_in);
        low_addr_strobe_out <= 1'b1;
        addr_mux_out <= {a[11:1], sz >= 3};
        seq_cycle_out <= sq;
        @(posedge clk_sys_in);
        high_addr_strobe_n_out <= 1'b0;
        addr_mux_out <= a[23:12];
        indivisible_out <= ind;
        @(posedge clk_sys_in);
        low_addr_strobe_out <= 1'b0;
        even_byte_strobe_n_out <= (sz == 1) && a[0];
        odd_byte_strobe_n_out <= (sz == 3) || ((sz == 1) && !a[0]);
        read_out <= rd;
        drive_out <= !rd;
        // lanes outside the transfer carry junk that must be ignored
        data_out <= (p & m) | (~m & ~{wd[15:0], wd[15:0]});
        for (int n = 0; n < 12 && resp == 0; n++) begin
            @(posedge clk_sys_in);
            if (ack_n_in === 1'b0) resp = 1;
            if (data_error_n_in === 1'b0) resp = 2;
        end
        rv = data_in;
        lk = lock_in;
        {even_byte_strobe_n_out, odd_byte_strobe_n_out} <= 2'h3;
        drive_out <= 1'b0;
        for (int n = 0; n < 12 && !(ack_n_in === 1'b1 && data_error_n_in === 1'b1); n++)
            @(posedge clk_sys_in);
        high_addr_strobe_n_out <= 1'b1;
        {seq_cycle_out, indivisible_out} <= 2'h0;
        @(posedge clk_sys_in);
    endtask
endmodule

// ==== verif/ebls_tb_top.sv ====
// bench: wide slave on page 0, narrow slave on page 1, wide sequential slave on page 2
// assumes the slaves decode their page from the upper address phase
`timescale 1ns/1ns
module expansion_bus_lane_steering_tb_top;
    logic        clk_sys_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [2:0]  ack_oe, data_error_n_oe, oe, lock, ack_n, data_error_n_n;
    logic [31:0] dout [3];
    logic [31:0] bus_d, mw;
    logic [31:0] last_d = 32'h0000_0000;
    logic [11:0] mux;
    logic        low_addr_strobe, uas_n, ev_n, od_n, rd, sq, ind, drv;
    logic [31:0] mem [3][16];
    int          num_errors = 0;
    int          num_checks = 0;

    always #5 clk_sys_in = ~clk_sys_in;
    // released data lines show a changing pattern, not the last value
    always_comb bus_d = oe[0] ? dout[0] : oe[1] ? dout[1] : oe[2] ? dout[2] : drv ? mw : ~last_d;
    always @(posedge clk_sys_in) last_d <= bus_d;

    ebls_master i_mst (.clk_sys_in(clk_sys_in), .ack_n_in(~|ack_oe),
        .data_error_n_in(~|data_error_n_oe), .data_in(bus_d), .lock_in(|lock),
        .addr_mux_out(mux), .low_addr_strobe_out(low_addr_strobe), .high_addr_strobe_n_out(uas_n),
        .even_byte_strobe_n_out(ev_n), .odd_byte_strobe_n_out(od_n), .read_out(rd),
        .seq_cycle_out(sq), .indivisible_out(ind), .drive_out(drv), .data_out(mw));

    for (genvar g = 0; g < 3; g++) begin : g_s
        ebls_slave #(.WIDE_CLASS(g != 1), .SEQ_CAP(g == 2), .BASE_PAGE(g))
            i_dut (.clk_sys_in(clk_sys_in),
            .sys_rst_in(sys_rst_in), .addr_mux_in(mux), .low_addr_strobe_in(low_addr_strobe),
            .high_addr_strobe_n_in(uas_n), .even_byte_strobe_n_in(ev_n),
            .odd_byte_strobe_n_in(od_n), .read_in(rd), .seq_cycle_in(sq),
            .indivisible_in(ind), .data_in(bus_d), .data_out(dout[g]), .data_oe_out(oe[g]),
            .ack_n_out(ack_n[g]), .ack_oe_out(ack_oe[g]), .data_error_n_out(data_error_n_n[g]),
            .data_error_oe_out(data_error_n_oe[g]), .lock_out(lock[g]));
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // each open-drain enable is high exactly while its line is driven low
    always @(negedge clk_sys_in) begin
        if (!sys_rst_in) begin
            check("oe", {26'h0, ack_oe ^ ack_n, data_error_n_oe ^ data_error_n_n}, 32'h3f);
        end
    end

    task automatic final_report();
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one transfer, compared with the longword model of the addressed slave
    task automatic op(input int d, input logic [5:0] ba, input int sz, input bit r,
                      input bit s, input bit i, input logic [31:0] wd);
        logic [31:0] rv, e, l;
        logic [7:0]  b;
        int          resp, sh;
        logic        lk;
        bit          bad;
        bad = (s && d != 2) || sz == 3 || (sz == 4 && d == 1);
        sh = 8 * (3 - int'(ba[1:0]));
        i_mst.xfer({d[11:0], 6'h00, ba}, sz, r, s, i, wd, rv, resp, lk);
        l = mem[d % 3][ba[5:2]];
        b = l[sh +: 8];
        if (d > 2) begin
            check("resp", resp, 0);
        end else begin
            check("resp", resp, bad ? 2 : 1);
            if (!bad) check("lock", lk, i);
            if (!bad && r) begin
                e = sz == 4 ? l : sz == 2 ? {16'h0, ba[1] ? l[15:0] : l[31:16]}
                    : ba[0] ? {24'h0, b} : {16'h0, b, 8'h0};
                check("rdata", rv, e);
            end else if (!bad) begin
                if (sz == 4) l = wd;
                else if (sz == 2 && ba[1]) l[15:0] = wd[15:0];
                else if (sz == 2) l[31:16] = wd[15:0];
                else l[sh +: 8] = wd[7:0];
                mem[d % 3][ba[5:2]] = l;
            end
        end
    endtask

    initial begin
        logic [31:0] v;
        int          sz;
        logic [5:0]  ba;
        v = $urandom(32'h7146);
        repeat (12) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys_in);
        for (int k = 0; k < 64; k++) op(k / 32, 6'((k % 16) * 4 + (k / 16 % 2) * 2), 2, 0, 0, 0, $urandom);
        for (int k = 0; k < 200; k++) begin
            sz = 1 << ($urandom % 3);
            ba = 6'($urandom) & ~6'(sz - 1);
            op($urandom % 2, ba, sz, 1'($urandom), 0, 1'($urandom), $urandom);
        end
        // refused shapes leave the array untouched, and a foreign page gets no answer
        op(0, 6'h04, 2, 0, 1, 0, 32'h1234_5678);
        op(0, 6'h08, 3, 0, 0, 0, 32'hdead_beef);
        op(1, 6'h0c, 4, 0, 0, 0, 32'h0bad_f00d);
        op(3, 6'h00, 2, 1, 0, 0, 32'h0000_0000);
        // the sequential-capable slave takes one-phase sequential cycles of each size
        op(2, 6'h10, 2, 0, 1, 0, 32'h0000_a5c3);
        op(2, 6'h11, 1, 0, 1, 1, 32'h0000_003c);
        op(2, 6'h10, 2, 1, 1, 0, 32'h0000_0000);
        op(2, 6'h14, 4, 0, 1, 0, 32'h5a69_c3f0);
        op(2, 6'h14, 4, 1, 0, 1, 32'h0000_0000);
        for (int k = 0; k < 64; k++) op(k % 2, 6'(k / 2 * 2), 2, 1, 0, 0, 32'h0000_0000);
        for (int k = 0; k < 16; k++) op(0, 6'(k * 4), 4, 1, 0, 0, 32'h0000_0000);
        final_report();
    end

    initial begin
        #200_000;
        num_errors++;
        final_report();
    end
endmodule
